// ==== rtl/lpta_consts.svh ====
/*
  Constants of the line port timing adjust block: command code, control
  byte fields, register offsets, reset values and conversion figures.
  Assumes inclusion by bare name from the design file.
*/
`ifndef LPTA_CONSTS_SVH
`define LPTA_CONSTS_SVH

// Command code and control byte fields
`define LPTA_CMD_ADJUST 8'hC3
`define LPTA_SEL_MSB 7
`define LPTA_SEL_LSB 5
`define LPTA_OD_BIT 4
`define LPTA_VAL_MSB 3
`define LPTA_VAL_LSB 0

// Register byte offsets
`define LPTA_OFF_CTRL 8'h00
`define LPTA_OFF_STAT 8'h04
`define LPTA_OFF_CODES 8'h08
`define LPTA_OFF_TIMES 8'h0C
`define LPTA_OFF_TIMES2 8'h10

// Status bit positions
`define LPTA_ST_BUSY 0
`define LPTA_ST_DROP 1
`define LPTA_ST_LINE 2

// Default value codes after reset
`define LPTA_DEF_RSTL 4'h6
`define LPTA_DEF_MSP 4'h6
`define LPTA_DEF_W0L 4'h6
`define LPTA_DEF_REC 4'h0
`define LPTA_DEF_WEAK_PULLUP_RESISTANCE 4'h0

// Conversion figures, in quarter microseconds; the two knees are value codes
`define LPTA_RSTL_STD_BASE 12'h6E0
`define LPTA_RSTL_STD_STEP 12'h050
`define LPTA_RSTL_OD_BASE 12'h0B0
`define LPTA_RSTL_OD_STEP 12'h008
`define LPTA_MSP_STD_LOW 12'h0E8
`define LPTA_MSP_STD_STEP 12'h008
`define LPTA_MSP_STD_MAX 12'h130
`define LPTA_MSP_OD_LOW 12'h016
`define LPTA_MSP_OD_STEP 12'h002
`define LPTA_MSP_OD_MAX 12'h02C
`define LPTA_W0L_STD_BASE 12'h0D0
`define LPTA_W0L_STD_STEP 12'h008
`define LPTA_W0L_STD_MAX 12'h118
`define LPTA_W0L_OD_ZERO 12'h014
`define LPTA_W0L_OD_LOW 12'h016
`define LPTA_W0L_OD_STEP 12'h002
`define LPTA_W0L_OD_MAX 12'h028
`define LPTA_REC_LOW 12'h00B
`define LPTA_REC_BASE 12'h015
`define LPTA_REC_STEP 12'h00A
`define LPTA_REC_MAX 12'h065
`define LPTA_REC_KNEE 4'h6
`define LPTA_WEAK_PULLUP_RESISTANCE_KNEE 4'h6

`endif

// ==== rtl/lpta_pkg.sv ====
/*
  Types of the line port timing adjust block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lpta_pkg;

  typedef logic [3:0] lpta_code_t;
  typedef logic [11:0] lpta_qus_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CMD = 4'h2,
    ST_WAIT = 4'h4,
    ST_DROP = 4'h8
  } lpta_state_e;

  typedef enum logic [2:0] {
    SEL_RSTL = 3'h0,
    SEL_MSP = 3'h1,
    SEL_W0L = 3'h2,
    SEL_REC = 3'h3,
    SEL_WEAK_PULLUP_RESISTANCE = 3'h4
  } lpta_sel_e;

endpackage

// ==== rtl/lpta_top.sv ====
/*
  Port parameter store of a serial-to-single-line bridge and the decoder
  of its port-adjust command, with a classic Wishbone register slave.
  Assumes a host-side byte engine that reports each received byte, the
  rising clock edge of each acknowledge bit and each stop condition, all
  synchronous to CLK_I.
*/
`timescale 1ns/1ps
`include "lpta_consts.svh"

// Notes on behaviour
// [R1] Command code C3h plus one control byte updates the selected parameter.
// [R2] Power-on reset and device reset restore every parameter default.
// [R3] The host sends the command only once line activity has finished.
// [R4] With the line busy at the command code, both bytes are refused.
// [R5] The update lands at the control byte acknowledge edge, no line action.
// [R6] On completion the read pointer moves to the port configuration.
// [R7] Control bits 7:5 select reset low, sample, write-zero, recovery, pullup.
// [R8] Control bit 4 chooses the standard or overdrive copy of a timing value.
// [R9] Recovery and pullup ignore bit 4 and hold one shared value.
// [R10] Control bits 3:0 are a value code converted per parameter.
// [R11] Reset low is 440+20n us standard and 44+2n us overdrive.
// [R12] Presence sample is 58 us rising 2 to 76, or 5.5 rising 0.5 to 11.
// [R13] Write-zero low is 52+2n to 70, or 5.0 then 5.5 up by 0.5 to 10.
// [R14] Recovery is 2.75 to code 5, then 5.25 up by 2.5 to 25.25.
// [R15] Pullup is 500 ohms to code 5 and 1000 ohms from code 6.
// [R16] Defaults are fixed constants of the design.
// [R17] Timing outputs follow the current speed and expose the stored code.
module lpta_top #(
  parameter int ADR_W = 8
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [ADR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  input wire logic BYTE_STB_I,
  input wire logic [7:0] BYTE_I,
  input wire logic FIRST_BYTE_I,
  input wire logic ACK_RISE_I,
  input wire logic STOP_I,
  output logic BYTE_ACK_O,
  input wire logic LINE_BUSY_I,
  input wire logic OVERDRIVE_I,
  input wire logic DEV_RESET_I,
  output logic PTR_PORT_O,
  output logic [3:0] RSTL_CODE_O,
  output logic [3:0] MSP_CODE_O,
  output logic [3:0] W0L_CODE_O,
  output logic [3:0] REC_CODE_O,
  output logic [11:0] RSTL_QUS_O,
  output logic [11:0] MSP_QUS_O,
  output logic [11:0] W0L_QUS_O,
  output logic [11:0] REC_QUS_O,
  output logic PULLUP_1K_O
);

  generate
    if (ADR_W < 8) begin : g_chk
      $error("ADR_W must be at least 8");
    end
  endgenerate

  localparam int NSLOT = 8;

  lpta_pkg::lpta_state_e state_q;
  lpta_pkg::lpta_state_e state_d;
  logic [7:0] ctrl_q;
  logic [7:0] last_q;
  logic byte_ack_q;
  logic ptr_q;
  logic drop_q;
  logic apply_bus;
  logic apply_sw;
  logic apply;
  logic [7:0] apply_byte;
  logic [2:0] slot;
  lpta_pkg::lpta_code_t code_q [NSLOT];
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic wb_hit;
  logic [7:0] wb_adr;
  logic ack_q;
  logic err_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  // Slot of a control byte: two copies per timing value, one for the rest
  function automatic logic [2:0] slot_of(input logic [7:0] b);
    logic [2:0] sel;
    sel = b[`LPTA_SEL_MSB:`LPTA_SEL_LSB];
    if (sel == lpta_pkg::SEL_REC) begin
      slot_of = 3'h6; // [R9]
    end else if (sel == lpta_pkg::SEL_WEAK_PULLUP_RESISTANCE) begin
      slot_of = 3'h7; // [R9]
    end else begin
      slot_of = {sel[1:0], b[`LPTA_OD_BIT]}; // [R8]
    end
  endfunction

  function automatic logic sel_ok(input logic [7:0] b);
    sel_ok = (b[`LPTA_SEL_MSB:`LPTA_SEL_LSB] <= lpta_pkg::SEL_WEAK_PULLUP_RESISTANCE); // [R7]
  endfunction

  function automatic lpta_pkg::lpta_code_t def_of(input int s);
    case (s)
      0, 1: def_of = `LPTA_DEF_RSTL;
      2, 3: def_of = `LPTA_DEF_MSP;
      4, 5: def_of = `LPTA_DEF_W0L;
      6: def_of = `LPTA_DEF_REC;
      default: def_of = `LPTA_DEF_WEAK_PULLUP_RESISTANCE;
    endcase
  endfunction

  // Conversions, results in quarter microseconds
  function automatic lpta_pkg::lpta_qus_t rstl_qus(
    input lpta_pkg::lpta_code_t n,
    input logic od
  );
    lpta_pkg::lpta_qus_t nn;
    nn = {8'h00, n};
    if (od) begin
      rstl_qus = 12'(`LPTA_RSTL_OD_BASE + nn * `LPTA_RSTL_OD_STEP); // [R11]
    end else begin
      rstl_qus = 12'(`LPTA_RSTL_STD_BASE + nn * `LPTA_RSTL_STD_STEP); // [R11]
    end
  endfunction

  function automatic lpta_pkg::lpta_qus_t msp_qus(
    input lpta_pkg::lpta_code_t n,
    input logic od
  );
    lpta_pkg::lpta_qus_t k;
    lpta_pkg::lpta_qus_t v;
    k = (n < 4'h2) ? 12'h000 : {8'h00, 4'(n - 4'h1)};
    if (od) begin
      v = 12'(`LPTA_MSP_OD_LOW + k * `LPTA_MSP_OD_STEP);
      msp_qus = (v > `LPTA_MSP_OD_MAX) ? `LPTA_MSP_OD_MAX : v; // [R12]
    end else begin
      v = 12'(`LPTA_MSP_STD_LOW + k * `LPTA_MSP_STD_STEP);
      msp_qus = (v > `LPTA_MSP_STD_MAX) ? `LPTA_MSP_STD_MAX : v; // [R12]
    end
  endfunction

  function automatic lpta_pkg::lpta_qus_t w0l_qus(
    input lpta_pkg::lpta_code_t n,
    input logic od
  );
    lpta_pkg::lpta_qus_t v;
    if (od) begin
      v = 12'(`LPTA_W0L_OD_LOW + {8'h00, 4'(n - 4'h1)} * `LPTA_W0L_OD_STEP);
      if (n == 4'h0) begin
        w0l_qus = `LPTA_W0L_OD_ZERO; // [R13]
      end else begin
        w0l_qus = (v > `LPTA_W0L_OD_MAX) ? `LPTA_W0L_OD_MAX : v; // [R13]
      end
    end else begin
      v = 12'(`LPTA_W0L_STD_BASE + {8'h00, n} * `LPTA_W0L_STD_STEP);
      w0l_qus = (v > `LPTA_W0L_STD_MAX) ? `LPTA_W0L_STD_MAX : v; // [R13]
    end
  endfunction

  function automatic lpta_pkg::lpta_qus_t rec_qus(
    input lpta_pkg::lpta_code_t n
  );
    lpta_pkg::lpta_qus_t v;
    v = 12'(`LPTA_REC_BASE
      + {8'h00, 4'(n - `LPTA_REC_KNEE)} * `LPTA_REC_STEP);
    if (n < `LPTA_REC_KNEE) begin
      rec_qus = `LPTA_REC_LOW; // [R14]
    end else begin
      rec_qus = (v > `LPTA_REC_MAX) ? `LPTA_REC_MAX : v; // [R14]
    end
  endfunction

  // Command sequencer on the host byte stream
  always_comb begin
    state_d = state_q;
    apply_bus = 1'b0;
    unique case (state_q)
      lpta_pkg::ST_IDLE: begin
        if (BYTE_STB_I && FIRST_BYTE_I && BYTE_I == `LPTA_CMD_ADJUST) begin
          state_d = LINE_BUSY_I ? lpta_pkg::ST_DROP : lpta_pkg::ST_CMD; // [R4]
        end
      end
      lpta_pkg::ST_CMD: begin
        if (STOP_I || (BYTE_STB_I && FIRST_BYTE_I)) begin
          state_d = lpta_pkg::ST_IDLE;
        end else if (BYTE_STB_I) begin
          state_d = sel_ok(BYTE_I) ? lpta_pkg::ST_WAIT : lpta_pkg::ST_DROP;
        end
      end
      lpta_pkg::ST_WAIT: begin
        if (ACK_RISE_I) begin
          apply_bus = 1'b1; // [R5]
          state_d = lpta_pkg::ST_IDLE;
        end else if (STOP_I) begin
          state_d = lpta_pkg::ST_IDLE;
        end
      end
      lpta_pkg::ST_DROP: begin
        if (STOP_I || (BYTE_STB_I && FIRST_BYTE_I)) begin
          state_d = lpta_pkg::ST_IDLE; // [R4]
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= lpta_pkg::ST_IDLE;
    end else if (DEV_RESET_I) begin
      state_q <= lpta_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Control byte capture
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= 8'h00;
    end else if (state_q == lpta_pkg::ST_CMD && BYTE_STB_I) begin
      ctrl_q <= BYTE_I; // [R1]
    end
  end

  // Acknowledge level for the byte just received
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      byte_ack_q <= 1'b0;
    end else if (BYTE_STB_I) begin
      if (state_q == lpta_pkg::ST_IDLE && FIRST_BYTE_I
          && BYTE_I == `LPTA_CMD_ADJUST) begin
        byte_ack_q <= !LINE_BUSY_I; // [R4]
      end else if (state_q == lpta_pkg::ST_CMD && !FIRST_BYTE_I) begin
        byte_ack_q <= sel_ok(BYTE_I);
      end else begin
        byte_ack_q <= 1'b0; // [R4]
      end
    end
  end

  // Software path writes a control byte while the line is idle
  assign wb_req = CYC_I && STB_I && !ack_q && !err_q;
  assign wb_adr = ADR_I[7:0];
  assign wb_hit = (wb_adr == `LPTA_OFF_CTRL) || (wb_adr == `LPTA_OFF_STAT)
    || (wb_adr == `LPTA_OFF_CODES) || (wb_adr == `LPTA_OFF_TIMES)
    || (wb_adr == `LPTA_OFF_TIMES2);
  assign wb_wr = ack_q && CYC_I && STB_I && WE_I;
  assign wb_rd = wb_req && !WE_I && wb_hit;
  assign apply_sw = wb_wr && wb_adr == `LPTA_OFF_CTRL && SEL_I[0]
    && !LINE_BUSY_I && sel_ok(DAT_I[7:0]);
  assign apply = apply_bus || (apply_sw && !DEV_RESET_I);
  assign apply_byte = apply_bus ? ctrl_q : DAT_I[7:0];
  assign slot = slot_of(apply_byte);

  // Parameter code store, one entry per slot
  generate
    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          code_q[s] <= def_of(s); // [R2] [R16]
        end else if (DEV_RESET_I) begin
          code_q[s] <= def_of(s); // [R2]
        end else if (apply && slot == 3'(s)) begin
          code_q[s] <= apply_byte[`LPTA_VAL_MSB:`LPTA_VAL_LSB]; // [R10]
        end
      end
    end
  endgenerate

  // Read pointer pulse and record of the last applied byte
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ptr_q <= 1'b0;
      last_q <= 8'h00;
    end else begin
      ptr_q <= apply; // [R6]
      if (DEV_RESET_I) begin
        last_q <= 8'h00;
      end else if (apply) begin
        last_q <= apply_byte;
      end
    end
  end

  // Dropped-command flag, set wins over clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      drop_q <= 1'b0;
    end else if (state_q == lpta_pkg::ST_IDLE && BYTE_STB_I && FIRST_BYTE_I
                 && BYTE_I == `LPTA_CMD_ADJUST && LINE_BUSY_I) begin
      drop_q <= 1'b1; // [R4]
    end else if (wb_wr && wb_adr == `LPTA_OFF_STAT && SEL_I[0]
                 && DAT_I[`LPTA_ST_DROP]) begin
      drop_q <= 1'b0;
    end
  end

  // Timing outputs for the current speed
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RSTL_CODE_O <= 4'h0;
      MSP_CODE_O <= 4'h0;
      W0L_CODE_O <= 4'h0;
      REC_CODE_O <= 4'h0;
      RSTL_QUS_O <= 12'h000;
      MSP_QUS_O <= 12'h000;
      W0L_QUS_O <= 12'h000;
      REC_QUS_O <= 12'h000;
      PULLUP_1K_O <= 1'b0;
    end else begin
      RSTL_CODE_O <= code_q[{2'b00, OVERDRIVE_I}]; // [R17]
      MSP_CODE_O <= code_q[{2'b01, OVERDRIVE_I}]; // [R17]
      W0L_CODE_O <= code_q[{2'b10, OVERDRIVE_I}]; // [R17]
      REC_CODE_O <= code_q[6];
      RSTL_QUS_O <= rstl_qus(code_q[{2'b00, OVERDRIVE_I}], OVERDRIVE_I);
      MSP_QUS_O <= msp_qus(code_q[{2'b01, OVERDRIVE_I}], OVERDRIVE_I);
      W0L_QUS_O <= w0l_qus(code_q[{2'b10, OVERDRIVE_I}], OVERDRIVE_I);
      REC_QUS_O <= rec_qus(code_q[6]); // [R9]
      PULLUP_1K_O <= (code_q[7] >= `LPTA_WEAK_PULLUP_RESISTANCE_KNEE); // [R15]
    end
  end

  // Register read mux
  always_comb begin
    rdat_d = 32'h0000_0000;
    unique case (wb_adr)
      `LPTA_OFF_CTRL: rdat_d = {24'h00_0000, last_q};
      `LPTA_OFF_STAT: begin
        rdat_d[`LPTA_ST_BUSY] = (state_q != lpta_pkg::ST_IDLE);
        rdat_d[`LPTA_ST_DROP] = drop_q;
        rdat_d[`LPTA_ST_LINE] = LINE_BUSY_I;
      end
      `LPTA_OFF_CODES: rdat_d = {code_q[7], code_q[6], code_q[5], code_q[4],
        code_q[3], code_q[2], code_q[1], code_q[0]};
      `LPTA_OFF_TIMES: rdat_d = {4'h0, MSP_QUS_O, 4'h0, RSTL_QUS_O};
      `LPTA_OFF_TIMES2: rdat_d = {3'h0, PULLUP_1K_O, REC_QUS_O,
        4'h0, W0L_QUS_O};
      default: rdat_d = 32'h0000_0000;
    endcase
  end

  // Wishbone answer, one cycle after the strobe
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req && wb_hit;
      err_q <= wb_req && !wb_hit;
      if (wb_rd) begin
        rdat_q <= rdat_d;
      end
    end
  end

  assign DAT_O = rdat_q;
  assign ACK_O = ack_q;
  assign ERR_O = err_q;
  assign BYTE_ACK_O = byte_ack_q;
  assign PTR_PORT_O = ptr_q;

endmodule

// ==== sim/lpta_host.sv ====
/* Host byte model: code byte, control byte, acknowledge edge, stop.
   Assumes the bench clock and an idle line when called. */
`timescale 1ns/1ps
module lpta_host (
  input wire logic clk_i,
  input wire logic byte_ack_i,
  output logic byte_stb_o,
  output logic [7:0] byte_o,
  output logic first_byte_o,
  output logic ack_rise_o,
  output logic stop_o
);
  initial {byte_stb_o, first_byte_o, ack_rise_o, stop_o, byte_o} = 12'h000;
  task automatic xfer(input logic [7:0] c, output logic a0, output logic a1);
    @(posedge clk_i);
    byte_stb_o <= 1'b1;
    first_byte_o <= 1'b1;
    byte_o <= 8'hC3;
    @(posedge clk_i);
    byte_stb_o <= 1'b0;
    first_byte_o <= 1'b0;
    byte_o <= 8'h3C;
    @(negedge clk_i);
    a0 = byte_ack_i;
    @(posedge clk_i);
    byte_stb_o <= 1'b1;
    byte_o <= c;
    @(posedge clk_i);
    byte_stb_o <= 1'b0;
    byte_o <= ~c;
    @(negedge clk_i);
    a1 = byte_ack_i;
    @(posedge clk_i);
    ack_rise_o <= 1'b1;
    @(posedge clk_i);
    ack_rise_o <= 1'b0;
    stop_o <= 1'b1;
    @(posedge clk_i);
    stop_o <= 1'b0;
  endtask
endmodule

// ==== sim/lpta_top_props.sv ====
/* Checker of the port timing adjust block, top ports only.
   Assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
module lpta_top_props (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire logic BYTE_STB_I,
  input wire logic [7:0] BYTE_I,
  input wire logic FIRST_BYTE_I,
  input wire logic ACK_RISE_I,
  input wire logic BYTE_ACK_O,
  input wire logic LINE_BUSY_I,
  input wire logic OVERDRIVE_I,
  input wire logic DEV_RESET_I,
  input wire logic PTR_PORT_O,
  input wire logic [3:0] RSTL_CODE_O,
  input wire logic [3:0] REC_CODE_O,
  input wire logic [11:0] RSTL_QUS_O,
  input wire logic [11:0] REC_QUS_O
);
  default clocking dc @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  logic code_in;
  assign code_in = BYTE_STB_I && FIRST_BYTE_I && BYTE_I == 8'hC3;

  a_wb_answer: assert property (CYC_I && STB_I && !ACK_O && !ERR_O
    |=> ACK_O || ERR_O) else $error("bus request not answered");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_err_pulse: assert property (ERR_O |=> !ERR_O)
    else $error("err longer than one cycle");
  a_ptr_pulse: assert property (PTR_PORT_O |=> !PTR_PORT_O)
    else $error("pointer pulse too long");
  a_ptr_cause: assert property (PTR_PORT_O && !$past(CYC_I)
    |-> $past(ACK_RISE_I)) else $error("pointer moved without ack edge");
  a_code_ack: assert property (code_in && !LINE_BUSY_I && !DEV_RESET_I
    |=> BYTE_ACK_O) else $error("command code not acknowledged");
  a_busy_nak: assert property (code_in && LINE_BUSY_I
    |=> !BYTE_ACK_O) else $error("command acknowledged while busy");
  a_ack_hold: assert property (!BYTE_STB_I && !DEV_RESET_I
    |=> $stable(BYTE_ACK_O)) else $error("byte ack changed without byte");
  a_rstl_decode: assert property (($stable(RSTL_CODE_O) &&
    $stable(OVERDRIVE_I))[*3] |-> RSTL_QUS_O == (OVERDRIVE_I ?
    12'h0B0 + 12'h008 * RSTL_CODE_O : 12'h6E0 + 12'h050 * RSTL_CODE_O))
    else $error("reset low time wrong");
  a_rec_decode: assert property ($stable(REC_CODE_O)[*3]
    |-> REC_QUS_O == (REC_CODE_O < 4'h6 ? 12'h00B : (REC_CODE_O == 4'hF ?
    12'h065 : 12'h015 + 12'h00A * (REC_CODE_O - 4'h6))))
    else $error("recovery time wrong");
endmodule

bind lpta_top lpta_top_props u_lpta_top_props (.CLK_I, .RST_I, .CYC_I,
  .STB_I, .ACK_O, .ERR_O, .BYTE_STB_I, .BYTE_I, .FIRST_BYTE_I, .ACK_RISE_I,
  .BYTE_ACK_O, .LINE_BUSY_I, .OVERDRIVE_I, .DEV_RESET_I, .PTR_PORT_O,
  .RSTL_CODE_O, .REC_CODE_O, .RSTL_QUS_O, .REC_QUS_O);

// ==== sim/lpta_top_tb.sv ====
/* Self-checking bench of the port timing adjust block.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module lpta_top_tb;
  logic CLK_I, RST_I, CYC_I, STB_I, WE_I, LINE_BUSY_I, OVERDRIVE_I;
  logic DEV_RESET_I, ACK_O, ERR_O, BYTE_ACK_O, PTR_PORT_O, PULLUP_1K_O;
  logic [7:0] ADR_I, byte_v, c;
  logic [3:0] SEL_I, RSTL_CODE_O, MSP_CODE_O, W0L_CODE_O, REC_CODE_O;
  logic [31:0] DAT_I, DAT_O, q, rng;
  logic [11:0] RSTL_QUS_O, MSP_QUS_O, W0L_QUS_O, REC_QUS_O;
  logic byte_stb, first_byte, ack_rise, stop, e;
  logic [3:0] ms [3];
  logic [3:0] mo [3];
  logic [3:0] mrec, mpu;
  int miscompares, checked, ptrs, cycles;

  lpta_top u_lpta_top (.CLK_I, .RST_I, .CYC_I, .STB_I, .WE_I, .ADR_I,
    .SEL_I, .DAT_I, .DAT_O, .ACK_O, .ERR_O, .BYTE_STB_I(byte_stb),
    .BYTE_I(byte_v), .FIRST_BYTE_I(first_byte), .ACK_RISE_I(ack_rise),
    .STOP_I(stop), .BYTE_ACK_O, .LINE_BUSY_I, .OVERDRIVE_I, .DEV_RESET_I,
    .PTR_PORT_O, .RSTL_CODE_O, .MSP_CODE_O, .W0L_CODE_O, .REC_CODE_O,
    .RSTL_QUS_O, .MSP_QUS_O, .W0L_QUS_O, .REC_QUS_O, .PULLUP_1K_O);
  lpta_host u_lpta_host (.clk_i(CLK_I), .byte_ack_i(BYTE_ACK_O),
    .byte_stb_o(byte_stb), .byte_o(byte_v), .first_byte_o(first_byte),
    .ack_rise_o(ack_rise), .stop_o(stop));

  always #20 CLK_I = ~CLK_I;
  always @(negedge CLK_I) if (PTR_PORT_O === 1'b1) ptrs++;
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic int lim(input int x, input int hi);
    return x < 0 ? 0 : (x > hi ? hi : x);
  endfunction
  function automatic logic [11:0] qus(input int s, input int o, input int n);
    int v;
    case (s)
      0: v = o ? 176 + 8 * n : 1760 + 80 * n;
      1: v = o ? 22 + 2 * lim(n - 1, 11) : 232 + 8 * lim(n - 1, 9);
      2: v = o ? (n == 0 ? 20 : 22 + 2 * lim(n - 1, 9)) : 208 + 8 * lim(n, 9);
      default: v = n < 6 ? 11 : 21 + 10 * lim(n - 6, 8);
    endcase
    return v[11:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic defaults();
    ms = '{4'h6, 4'h6, 4'h6};
    mo = '{4'h6, 4'h6, 4'h6};
    mrec = 4'h0;
    mpu = 4'h0;
  endtask
  task automatic apply(input logic [7:0] b);
    if (b[7:5] < 3'h3 && b[4]) mo[b[6:5]] = b[3:0];
    else if (b[7:5] < 3'h3) ms[b[6:5]] = b[3:0];
    else if (b[7:5] == 3'h3) mrec = b[3:0];
    else mpu = b[3:0];
  endtask
  task automatic verify();
    logic [3:0] cd [3];
    for (int o = 0; o < 2; o++) begin
      @(posedge CLK_I);
      OVERDRIVE_I <= o[0];
      repeat (3) @(posedge CLK_I);
      @(negedge CLK_I);
      for (int i = 0; i < 3; i++) cd[i] = o ? mo[i] : ms[i];
      check(32'(RSTL_CODE_O), 32'(cd[0]));
      check(32'(MSP_CODE_O), 32'(cd[1]));
      check(32'(W0L_CODE_O), 32'(cd[2]));
      check(32'(REC_CODE_O), 32'(mrec));
      check(32'(RSTL_QUS_O), 32'(qus(0, o, cd[0])));
      check(32'(MSP_QUS_O), 32'(qus(1, o, cd[1])));
      check(32'(W0L_QUS_O), 32'(qus(2, o, cd[2])));
      check(32'(REC_QUS_O), 32'(qus(3, o, mrec)));
      check(32'(PULLUP_1K_O), 32'(mpu > 4'h5));
    end
  endtask
  task automatic cmd(input logic [7:0] b, input logic x0, input logic x1);
    logic a0, a1;
    int n0;
    n0 = ptrs;
    u_lpta_host.xfer(b, a0, a1);
    repeat (3) @(posedge CLK_I);
    check(32'(a0), 32'(x0));
    check(32'(a1), 32'(x1));
    check(ptrs - n0, 32'(x1));
    if (x1) apply(b);
    verify();
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'h3, w, a, d};
    do begin
      @(posedge CLK_I);
    end while (ACK_O !== 1'b1 && ERR_O !== 1'b1);
    q = DAT_O;
    e = ERR_O;
    {CYC_I, STB_I} <= 2'h0;
  endtask

  initial begin
    {CLK_I, RST_I, CYC_I, STB_I, WE_I, LINE_BUSY_I} = 6'h10;
    {OVERDRIVE_I, DEV_RESET_I, ADR_I, DAT_I, SEL_I} = 46'h0F;
    rng = 32'hE5F8;
    defaults();
    repeat (12) @(posedge CLK_I);
    RST_I <= 1'b0;
    verify();
    $display("test defaults done");
    for (int i = 0; i < 44; i++) begin
      rng = xs(rng);
      c = i < 20 ? {3'(i / 4), i[1], i[0] ? 4'hF : 4'h0} : rng[7:0];
      cmd(c, 1'b1, c[7:5] <= 3'h4);
    end
    $display("test commands done");
    @(posedge CLK_I);
    LINE_BUSY_I <= 1'b1;
    cmd(8'h0F, 1'b0, 1'b0);
    @(posedge CLK_I);
    LINE_BUSY_I <= 1'b0;
    cmd(8'hB5, 1'b1, 1'b0);
    wb(1'b0, 8'h04, 32'h0);
    check(q, 32'h2);
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b0, 8'h04, 32'h0);
    check(q, 32'h0);
    $display("test refusals done");
    wb(1'b0, 8'h08, 32'h0);
    check(q, {mpu, mrec, mo[2], ms[2], mo[1], ms[1], mo[0], ms[0]});
    wb(1'b0, 8'h14, 32'h0);
    check(32'(e), 32'h1);
    wb(1'b1, 8'h00, 32'h79);
    apply(8'h79);
    wb(1'b0, 8'h00, 32'h0);
    check(q, 32'h79);
    @(posedge CLK_I);
    SEL_I <= 4'hE;
    wb(1'b1, 8'h00, 32'h63);
    @(posedge CLK_I);
    SEL_I <= 4'hF;
    verify();
    $display("test register bus done");
    @(posedge CLK_I);
    DEV_RESET_I <= 1'b1;
    @(posedge CLK_I);
    DEV_RESET_I <= 1'b0;
    defaults();
    verify();
    $display("test device reset done");
    cmd(8'h1A, 1'b1, 1'b1);
    @(posedge CLK_I);
    RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    defaults();
    verify();
    $display("test power-on reset done");
    tally_and_finish();
  end
endmodule
